// ===== pdc_top.sv
// Four-channel duty modulator with shared port pins and Wishbone registers
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pdc_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Part state
  input wire logic special_mode_n_i,
  input wire logic wait_mode_i,
  input wire logic background_mode_i,
  // Port pins
  input wire logic [7:0] port_pin_i,
  output logic [7:0] port_pin_o,
  output logic [7:0] port_pin_oe_o,
  output logic [7:0] port_pullup_o,
  output logic port_drive_reduce_o
);
  // Software registers
  logic [3:0] channel_enable_q;
  logic [3:0] channel_polarity_q;
  logic [7:0] scale_value_a_q;
  logic [7:0] scale_value_b_q;
  logic [7:0] channel_period_q [pdc_pkg::NCH];
  logic [7:0] channel_duty_compare_q [pdc_pkg::NCH];
  logic [4:0] modulator_global_control_q;
  logic [2:0] factory_test_override_q;
  logic [7:0] shared_port_data_q;
  logic [7:0] shared_port_direction_q;
  // Scale counters and channel results
  logic [7:0] scale_cnt_a_q;
  logic [7:0] scale_cnt_b_q;
  logic [3:0] cnt_wr;
  logic [3:0] ch_level;
  logic [7:0] ch_count [pdc_pkg::NCH];
  logic run;
  logic tick_a;
  logic tick_b;
  logic [3:0] ch_tick;
  // Bus decode
  logic wr_stb;
  logic [7:0] wr_byte;
  logic [1:0] idx;
  logic [7:0] grp;
  logic [31:0] rd_d;
  logic [7:0] port_rd;
  logic [7:0] dir_eff;

  // Write strobe for the low byte lane; no register is wider than one byte
  assign wr_stb = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign wr_byte = dat_i[7:0];
  assign idx = adr_i[3:2];
  assign grp = adr_i & pdc_pkg::GROUP_MASK;

  // Bus answer one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Channel enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_enable_q <= 4'h0;
    end else if (wr_stb && adr_i == pdc_pkg::OFF_ENABLE) begin
      channel_enable_q <= wr_byte[3:0];
    end
  end

  // Channel polarity; a change mid-period is only fully seen from the next rollover
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_polarity_q <= 4'h0;
    end else if (wr_stb && adr_i == pdc_pkg::OFF_POLARITY) begin
      channel_polarity_q <= wr_byte[3:0];
    end
  end

  // Per-channel period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < pdc_pkg::NCH; i++) begin
        channel_period_q[i] <= pdc_pkg::RST_PERIOD;
      end
    end else if (wr_stb && grp == pdc_pkg::OFF_PERIOD0) begin
      channel_period_q[idx] <= wr_byte;
    end
  end

  // Per-channel duty; the written value reads back, the channel keeps its own live copy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < pdc_pkg::NCH; i++) begin
        channel_duty_compare_q[i] <= pdc_pkg::RST_DUTY;
      end
    end else if (wr_stb && grp == pdc_pkg::OFF_DUTY0) begin
      channel_duty_compare_q[idx] <= wr_byte;
    end
  end

  // Counter writes restart a channel unless the test override blocks it
  always_comb begin
    cnt_wr = 4'h0;
    if (wr_stb && grp == pdc_pkg::OFF_COUNT0 &&
        !factory_test_override_q[pdc_pkg::TST_CNT_WR_RST_DIS]) begin
      cnt_wr[idx] = 1'b1;
    end
  end

  // Global control; the alignment bit is taken as written, software must
  // change it with channels off or a truncated period results
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      modulator_global_control_q <= 5'h00;
    end else if (wr_stb && adr_i == pdc_pkg::OFF_CONTROL) begin
      modulator_global_control_q <= wr_byte[4:0];
    end
  end

  // Test overrides exist only in special mode and are held clear otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      factory_test_override_q <= 3'h0;
    end else if (special_mode_n_i) begin
      factory_test_override_q <= 3'h0;
    end else if (wr_stb && adr_i == pdc_pkg::OFF_TEST) begin
      factory_test_override_q <= wr_byte[2:0] & pdc_pkg::TST_MASK;
    end
  end

  // Port latch; always stores, the pins follow separately
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shared_port_data_q <= pdc_pkg::RST_BYTE;
    end else if (wr_stb && adr_i == pdc_pkg::OFF_PORT_DATA) begin
      shared_port_data_q <= wr_byte;
    end
  end

  // Port direction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shared_port_direction_q <= pdc_pkg::RST_BYTE;
    end else if (wr_stb && adr_i == pdc_pkg::OFF_PORT_DIR) begin
      shared_port_direction_q <= wr_byte;
    end
  end

  // Clock generator runs only with a channel on and no halting condition
  assign run = (|channel_enable_q) &&
               !(modulator_global_control_q[pdc_pkg::CTL_HALT_IN_WAIT] && wait_mode_i) &&
               !(modulator_global_control_q[pdc_pkg::CTL_STOP_IN_BGND] && background_mode_i);
  assign tick_a = run && scale_cnt_a_q == pdc_pkg::DUTY_ZERO;
  assign tick_b = run && scale_cnt_b_q == pdc_pkg::DUTY_ZERO;

  // Scale value A
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scale_value_a_q <= pdc_pkg::RST_BYTE;
    end else if (wr_stb && adr_i == pdc_pkg::OFF_SCALE_A) begin
      scale_value_a_q <= wr_byte;
    end
  end

  // Scale counter A: reloads at zero; a write reloads at once unless the test bit blocks it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scale_cnt_a_q <= pdc_pkg::RST_BYTE;
    end else if (wr_stb && adr_i == pdc_pkg::OFF_SCALE_A &&
                 !factory_test_override_q[pdc_pkg::TST_SCALE_LOAD_DIS]) begin
      scale_cnt_a_q <= wr_byte;
    end else if (tick_a) begin
      scale_cnt_a_q <= scale_value_a_q;
    end else if (run) begin
      scale_cnt_a_q <= scale_cnt_a_q - 8'h01;
    end
  end

  // Scale value B
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scale_value_b_q <= pdc_pkg::RST_BYTE;
    end else if (wr_stb && adr_i == pdc_pkg::OFF_SCALE_B) begin
      scale_value_b_q <= wr_byte;
    end
  end

  // Scale counter B; held while halted so a resumed channel keeps its phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scale_cnt_b_q <= pdc_pkg::RST_BYTE;
    end else if (wr_stb && adr_i == pdc_pkg::OFF_SCALE_B &&
                 !factory_test_override_q[pdc_pkg::TST_SCALE_LOAD_DIS]) begin
      scale_cnt_b_q <= wr_byte;
    end else if (tick_b) begin
      scale_cnt_b_q <= scale_value_b_q;
    end else if (run) begin
      scale_cnt_b_q <= scale_cnt_b_q - 8'h01;
    end
  end

  // Channels 0 and 1 count on scale A, channels 2 and 3 on scale B
  assign ch_tick = {tick_b, tick_b, tick_a, tick_a};

  // One counter, comparator and level stage per channel
  for (genvar g = 0; g < pdc_pkg::NCH; g++) begin : g_ch
    pdc_channel u_ch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(ch_tick[g]),
      .en_i(channel_enable_q[g]),
      .center_i(modulator_global_control_q[pdc_pkg::CTL_CENTER_ALIGN]),
      .pol_i(channel_polarity_q[g]),
      .per_rst_dis_i(factory_test_override_q[pdc_pkg::TST_PER_RST_DIS]),
      .period_i(channel_period_q[g]),
      .duty_i(channel_duty_compare_q[g]),
      .cnt_wr_i(cnt_wr[g]),
      .level_o(ch_level[g]),
      .count_o(ch_count[g])
    );
  end

  // Effective direction: an enabled channel forces its pin to output
  assign dir_eff = shared_port_direction_q | {4'h0, channel_enable_q};

  // Port readback: pin level for inputs, latch for outputs
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      port_rd[i] = dir_eff[i] ? shared_port_data_q[i] : port_pin_i[i];
    end
  end

  // Read data mux; unmapped addresses read as zero
  always_comb begin
    rd_d = 32'h0000_0000;
    case (grp)
      8'h00: begin
        case (adr_i)
          pdc_pkg::OFF_ENABLE: rd_d[3:0] = channel_enable_q;
          pdc_pkg::OFF_POLARITY: rd_d[3:0] = channel_polarity_q;
          pdc_pkg::OFF_SCALE_A: rd_d[7:0] = scale_value_a_q;
          pdc_pkg::OFF_SCALE_B: rd_d[7:0] = scale_value_b_q;
          default: rd_d = 32'h0000_0000;
        endcase
      end
      pdc_pkg::OFF_COUNT0: rd_d[7:0] = ch_count[idx];
      pdc_pkg::OFF_PERIOD0: rd_d[7:0] = channel_period_q[idx];
      pdc_pkg::OFF_DUTY0: rd_d[7:0] = channel_duty_compare_q[idx];
      8'h40: begin
        case (adr_i)
          pdc_pkg::OFF_CONTROL: rd_d[4:0] = modulator_global_control_q;
          pdc_pkg::OFF_TEST: rd_d[2:0] = factory_test_override_q;
          pdc_pkg::OFF_PORT_DATA: rd_d[7:0] = port_rd;
          pdc_pkg::OFF_PORT_DIR: rd_d[7:0] = shared_port_direction_q;
          default: rd_d = 32'h0000_0000;
        endcase
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Read data registered together with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !ack_o) begin
      dat_o <= rd_d;
    end
  end

  // Pin enables; a register stage keeps outputs glitch free at one cycle of lag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_pin_oe_o <= 8'h00;
    end else begin
      port_pin_oe_o <= dir_eff;
    end
  end

  // Pin levels: pins 3 to 0 follow an enabled channel, the latch otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_pin_o <= 8'h00;
    end else begin
      port_pin_o <= {shared_port_data_q[7:4],
                     (channel_enable_q & ch_level) |
                     (~channel_enable_q & shared_port_data_q[3:0])};
    end
  end

  // Pullups follow the effective direction, so a pin taken by a channel loses its pullup
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_pullup_o <= 8'h00;
    end else begin
      port_pullup_o <= {8{modulator_global_control_q[pdc_pkg::CTL_PULLUP_EN]}} & ~dir_eff;
    end
  end

  // Drive strength applies to every pin alike
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_drive_reduce_o <= 1'b0;
    end else begin
      port_drive_reduce_o <= modulator_global_control_q[pdc_pkg::CTL_DRIVE_REDUCE];
    end
  end
endmodule
`default_nettype wire

// ===== pdc_pkg.sv
// Package with register map, field positions and reset values of the duty/port block
`default_nettype none
package pdc_pkg;
  localparam int unsigned NCH = 4;
  // Word-aligned byte offsets on the register bus
  localparam logic [7:0] OFF_ENABLE = 8'h00;
  localparam logic [7:0] OFF_POLARITY = 8'h04;
  localparam logic [7:0] OFF_SCALE_A = 8'h08;
  localparam logic [7:0] OFF_SCALE_B = 8'h0C;
  localparam logic [7:0] OFF_COUNT0 = 8'h10;
  localparam logic [7:0] OFF_PERIOD0 = 8'h20;
  localparam logic [7:0] OFF_DUTY0 = 8'h30;
  localparam logic [7:0] OFF_CONTROL = 8'h40;
  localparam logic [7:0] OFF_TEST = 8'h44;
  localparam logic [7:0] OFF_PORT_DATA = 8'h48;
  localparam logic [7:0] OFF_PORT_DIR = 8'h4C;
  // Per-channel register groups: four words, index in address bits 3:2
  localparam logic [7:0] GROUP_MASK = 8'hF0;
  // Global control field positions
  localparam int unsigned CTL_HALT_IN_WAIT = 4;
  localparam int unsigned CTL_CENTER_ALIGN = 3;
  localparam int unsigned CTL_DRIVE_REDUCE = 2;
  localparam int unsigned CTL_PULLUP_EN = 1;
  localparam int unsigned CTL_STOP_IN_BGND = 0;
  // Test override field positions
  localparam int unsigned TST_CNT_WR_RST_DIS = 2;
  localparam int unsigned TST_PER_RST_DIS = 1;
  localparam int unsigned TST_SCALE_LOAD_DIS = 0;
  localparam logic [2:0] TST_MASK = 3'h7;
  // Reset values and duty boundary constants
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_DUTY = 8'hFF;
  localparam logic [7:0] DUTY_ALL_ONES = 8'hFF;
  localparam logic [7:0] DUTY_ZERO = 8'h00;
endpackage
`default_nettype wire

// ===== pdc_channel.sv
// One modulator channel: counter, buffered duty and period, output level
`timescale 1ns/1ps
`default_nettype none
module pdc_channel (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Timing and mode
  input wire logic tick_i,
  input wire logic en_i,
  input wire logic center_i,
  input wire logic pol_i,
  input wire logic per_rst_dis_i,
  // Software values
  input wire logic [7:0] period_i,
  input wire logic [7:0] duty_i,
  input wire logic cnt_wr_i,
  // Results
  output logic level_o,
  output logic [7:0] count_o
);
  logic [7:0] cnt_q;
  logic up_q;
  logic lvl_q;
  logic [7:0] per_act_q;
  logic [7:0] duty_act_q;
  logic [7:0] cnt_d;
  logic up_d;
  logic roll;

  // Next count; left mode wraps at period, center mode turns round at both ends
  always_comb begin
    cnt_d = cnt_q;
    up_d = up_q;
    roll = 1'b0;
    if (!center_i) begin
      if (cnt_q == per_act_q && !per_rst_dis_i) begin
        cnt_d = pdc_pkg::DUTY_ZERO;
        roll = 1'b1;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end else if (per_act_q != pdc_pkg::DUTY_ZERO) begin
      if (up_q) begin
        if (cnt_q >= per_act_q) begin
          up_d = 1'b0;
          cnt_d = cnt_q - 8'h01;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end else if (cnt_q == pdc_pkg::DUTY_ZERO) begin
        up_d = 1'b1;
        cnt_d = 8'h01;
        roll = 1'b1;
      end else begin
        cnt_d = cnt_q - 8'h01;
      end
    end
  end

  // Counter, live compare values and waveform level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
      up_q <= 1'b1;
      lvl_q <= 1'b0;
      per_act_q <= pdc_pkg::RST_PERIOD;
      duty_act_q <= pdc_pkg::RST_DUTY;
    end else if (cnt_wr_i) begin
      // A counter write restarts the period with fresh values
      cnt_q <= 8'h00;
      up_q <= 1'b1;
      lvl_q <= pol_i;
      per_act_q <= period_i;
      duty_act_q <= duty_i;
    end else if (!en_i) begin
      per_act_q <= period_i;
      duty_act_q <= duty_i;
      up_q <= 1'b1;
      lvl_q <= pol_i;
    end else if (tick_i) begin
      cnt_q <= cnt_d;
      up_q <= up_d;
      if (roll) begin
        per_act_q <= period_i;
        duty_act_q <= duty_i;
        lvl_q <= pol_i;
      end else if (cnt_d == duty_act_q) begin
        lvl_q <= ~lvl_q;
      end
    end
  end

  // Boundary cases override the waveform
  always_comb begin
    if (duty_act_q == pdc_pkg::DUTY_ALL_ONES && per_act_q != pdc_pkg::DUTY_ZERO) begin
      level_o = ~pol_i;
    end else if (duty_act_q == pdc_pkg::DUTY_ZERO) begin
      level_o = pol_i;
    end else if (duty_act_q >= per_act_q) begin
      level_o = pol_i;
    end else begin
      level_o = lvl_q;
    end
  end

  assign count_o = cnt_q;
endmodule
`default_nettype wire

// ===== pdc_load.sv
// Model of the loads and pull resistors on the shared port pins
`timescale 1ns/1ps
`default_nettype none
module pdc_load (
  // From the block
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] pullup_i,
  // Level the outside world puts on undriven pins
  input wire logic [7:0] ext_i,
  // Resolved pin levels
  output logic [7:0] pin_o
);
  // A driven pin shows the block; an undriven one the pullup or the far side
  assign pin_o = (oe_i & drv_i) | (~oe_i & (pullup_i | ext_i));
endmodule
`default_nettype wire

// ===== pdc_chk.sv
// Port-level checker for the duty/port block
`timescale 1ns/1ps
`default_nettype none
module pdc_chk (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Pins
  input wire logic [7:0] port_pin_oe_o,
  input wire logic [7:0] port_pullup_o,
  input wire logic port_drive_reduce_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic wr;
  logic rdr_q;
  logic [3:0] en_q;
  logic [7:0] dir_q;
  assign take = cyc_i && stb_i && !ack_o;
  assign wr = take && we_i && sel_i[0];
  // Settings as written, so pin checks need not decode the bus twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdr_q <= 1'b0;
      en_q <= 4'h0;
      dir_q <= 8'h00;
    end else if (wr) begin
      if (adr_i == pdc_pkg::OFF_CONTROL) rdr_q <= dat_i[pdc_pkg::CTL_DRIVE_REDUCE];
      if (adr_i == pdc_pkg::OFF_ENABLE) en_q <= dat_i[3:0];
      if (adr_i == pdc_pkg::OFF_PORT_DIR) dir_q <= dat_i[7:0];
    end
  end
  sequence s_wr(logic [7:0] a);
    wr && adr_i == a;
  endsequence
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_ack_answer: assert property (take |=> ack_o) else $error("request not answered");
  a_reset_idle: assert property ($fell(rst_i) |-> !ack_o && port_pin_oe_o == 8'h00)
    else $error("outputs active after reset");
  a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h000000) else $error("upper read bits set");
  a_drive_follow: assert property (s_wr(pdc_pkg::OFF_CONTROL) |=> ##2 port_drive_reduce_o == rdr_q)
    else $error("drive strength wrong");
  a_enable_owns: assert property (s_wr(pdc_pkg::OFF_ENABLE) |=> ##2 (port_pin_oe_o[3:0] & en_q) == en_q)
    else $error("enabled pin not output");
  a_dir_upper: assert property (s_wr(pdc_pkg::OFF_PORT_DIR) |=> ##2 port_pin_oe_o[7:4] == dir_q[7:4])
    else $error("direction not applied");
  a_pullup_inputs: assert property ($stable(port_pin_oe_o) |-> (port_pullup_o & port_pin_oe_o) == 8'h00)
    else $error("pullup on output pin");
endmodule
`default_nettype wire

// ===== testbench.sv
// Register-level testbench of the duty/port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; $display("mismatch %0t got %0h exp %0h", $time, a, b); end end
module testbench;
  logic clk, rst, cyc, stb, we, spm, wt, bg, pdr, p0;
  logic [7:0] adr, wdat, oe, pup, pin_o, pin_i, c, c2;
  logic [31:0] rdat;
  logic ack;
  int num_errors, tests_run, i, hi, rise;
  // Duty, polarity and expected level of the boundary cases
  logic [9:0] bt [6] = '{10'h3FE, 10'h3FD, 10'h083, 10'h080, 10'h003, 10'h000};
  pdc_top u_dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
    .dat_i({24'h000000, wdat}), .dat_o(rdat), .ack_o(ack), .special_mode_n_i(spm), .wait_mode_i(wt),
    .background_mode_i(bg), .port_pin_i(pin_i), .port_pin_o(pin_o), .port_pin_oe_o(oe),
    .port_pullup_o(pup), .port_drive_reduce_o(pdr));
  pdc_load u_load (.drv_i(pin_o), .oe_i(oe), .pullup_i(pup), .ext_i(8'h3C), .pin_o(pin_i));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic conclude();
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One classic cycle; waits for ack under a bound
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    {cyc, stb, we} <= {2'b11, w};
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      $display("mismatch %0t bus request not answered", $time);
      conclude();
    end
    q = rdat[7:0];
    {cyc, stb, we} <= 3'b000;
    @(posedge clk);
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic r(input logic [7:0] a, output logic [7:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    r(a, q);
    `CHK(q, e)
  endtask
  // High cycles and rising edges of one channel pin
  task automatic meas(input int n, output int h, output int e);
    logic p;
    h = 0;
    e = 0;
    p = pin_o[0];
    repeat (n) begin
      @(posedge clk);
      h += pin_o[0];
      e += pin_o[0] && !p;
      p = pin_o[0];
    end
  endtask
  // Restart channel 0 with the given duty and run it
  task automatic run(input logic [7:0] d);
    w(pdc_pkg::OFF_DUTY0, d);
    w(pdc_pkg::OFF_COUNT0, 8'h00);
    w(pdc_pkg::OFF_ENABLE, 8'h01);
    repeat (20) @(posedge clk);
  endtask
  // Bound well above the twelve hundred or so cycles the sequence needs
  initial begin
    #100000;
    num_errors++;
    $display("mismatch %0t run did not finish in time", $time);
    conclude();
  end
  initial begin
    rst <= 1'b1;
    {cyc, stb, we, wt, bg} <= 5'h00;
    spm <= 1'b1;
    adr <= 8'h00;
    wdat <= 8'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(oe, 8'h00)
    rc(pdc_pkg::OFF_DUTY0, 8'hFF);
    w(pdc_pkg::OFF_PERIOD0, 8'h10);
    for (i = 0; i < 6; i++) begin
      w(pdc_pkg::OFF_POLARITY, {7'h00, bt[i][1]});
      run(bt[i][9:2]);
      meas(40, hi, rise);
      `CHK(hi, bt[i][0] ? 40 : 0)
      w(pdc_pkg::OFF_ENABLE, 8'h00);
    end
    w(pdc_pkg::OFF_PERIOD0, 8'h09);
    for (i = 1; i >= 0; i--) begin
      w(pdc_pkg::OFF_POLARITY, i[7:0]);
      run(8'h04);
      meas(100, hi, rise);
      `CHK(hi, i ? 40 : 60)
      `CHK(rise, 10)
    end
    // Duty change while running lands at a rollover
    w(pdc_pkg::OFF_DUTY0, 8'h07);
    rc(pdc_pkg::OFF_DUTY0, 8'h07);
    repeat (20) @(posedge clk);
    meas(100, hi, rise);
    `CHK(hi, 30)
    // Frozen channel: a running duty write must not reach the pin before rollover
    w(pdc_pkg::OFF_CONTROL, 8'h10);
    wt <= 1'b1;
    repeat (3) @(posedge clk);
    p0 = pin_o[0];
    w(pdc_pkg::OFF_DUTY0, 8'h00);
    repeat (3) @(posedge clk);
    `CHK(pin_o[0], p0)
    w(pdc_pkg::OFF_DUTY0, 8'hFF);
    repeat (3) @(posedge clk);
    `CHK(pin_o[0], p0)
    wt <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK(pin_o[0], 1'b1)
    w(pdc_pkg::OFF_ENABLE, 8'h00);
    w(pdc_pkg::OFF_CONTROL, 8'h08);
    w(pdc_pkg::OFF_PERIOD0, 8'h08);
    run(8'h03);
    meas(32, hi, rise);
    `CHK(rise, 2)
    `CHK(hi, 20)
    for (i = 0; i < 2; i++) begin
      w(pdc_pkg::OFF_CONTROL, i ? 8'h01 : 8'h10);
      {wt, bg} <= i ? 2'b01 : 2'b10;
      repeat (3) @(posedge clk);
      r(pdc_pkg::OFF_COUNT0, c);
      repeat (10) @(posedge clk);
      rc(pdc_pkg::OFF_COUNT0, c);
      {wt, bg} <= 2'b00;
      repeat (3) @(posedge clk);
      r(pdc_pkg::OFF_COUNT0, c2);
      `CHK(c2 !== c, 1'b1)
    end
    w(pdc_pkg::OFF_TEST, 8'h07);
    rc(pdc_pkg::OFF_TEST, 8'h00);
    spm <= 1'b0;
    w(pdc_pkg::OFF_TEST, 8'h06);
    rc(pdc_pkg::OFF_TEST, 8'h06);
    repeat (30) @(posedge clk);
    r(pdc_pkg::OFF_COUNT0, c);
    `CHK(c > 8'h08, 1'b1)
    w(pdc_pkg::OFF_ENABLE, 8'h00);
    r(pdc_pkg::OFF_COUNT0, c);
    w(pdc_pkg::OFF_COUNT0, 8'h00);
    rc(pdc_pkg::OFF_COUNT0, c);
    w(pdc_pkg::OFF_TEST, 8'h00);
    w(pdc_pkg::OFF_COUNT0, 8'h00);
    rc(pdc_pkg::OFF_COUNT0, 8'h00);
    // Scale write with loading blocked leaves the idle scale counter at zero
    w(pdc_pkg::OFF_TEST, 8'h01);
    w(pdc_pkg::OFF_SCALE_A, 8'h40);
    w(pdc_pkg::OFF_ENABLE, 8'h01);
    rc(pdc_pkg::OFF_COUNT0, 8'h01);
    w(pdc_pkg::OFF_ENABLE, 8'h00);
    w(pdc_pkg::OFF_TEST, 8'h00);
    w(pdc_pkg::OFF_SCALE_A, 8'h40);
    w(pdc_pkg::OFF_COUNT0, 8'h00);
    w(pdc_pkg::OFF_ENABLE, 8'h01);
    rc(pdc_pkg::OFF_COUNT0, 8'h00);
    w(pdc_pkg::OFF_ENABLE, 8'h00);
    w(pdc_pkg::OFF_TEST, 8'h01);
    spm <= 1'b1;
    repeat (2) @(posedge clk);
    rc(pdc_pkg::OFF_TEST, 8'h00);
    // General-purpose port use, then a channel taking a pin
    w(pdc_pkg::OFF_PORT_DIR, 8'hF0);
    w(pdc_pkg::OFF_PORT_DATA, 8'hA5);
    repeat (3) @(posedge clk);
    `CHK(oe, 8'hF0)
    `CHK(pin_o[7:4], 4'hA)
    rc(pdc_pkg::OFF_PORT_DATA, 8'hAC);
    w(pdc_pkg::OFF_ENABLE, 8'h02);
    repeat (3) @(posedge clk);
    `CHK(oe, 8'hF2)
    `CHK(pin_o[1], 1'b1)
    rc(pdc_pkg::OFF_PORT_DIR, 8'hF0);
    w(pdc_pkg::OFF_ENABLE, 8'h00);
    w(pdc_pkg::OFF_CONTROL, 8'h06);
    repeat (3) @(posedge clk);
    `CHK(pup, 8'h0F)
    `CHK(pdr, 1'b1)
    rc(8'hFC, 8'h00);
    conclude();
  end
endmodule
bind pdc_top pdc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .port_pin_oe_o(port_pin_oe_o),
  .port_pullup_o(port_pullup_o), .port_drive_reduce_o(port_drive_reduce_o));
`default_nettype wire
